// *** brc_pkg.sv ***
`default_nettype none
package brc_pkg;
   // ************************************************************
   // APB register map, byte offsets
   // ************************************************************
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_OPERAND = 8'h04;
   localparam logic [7:0] OFS_PC      = 8'h08;
   localparam logic [7:0] OFS_STATUS  = 8'h0C;
   localparam logic [7:0] OFS_OPCODE  = 8'h10;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int CTRL_START_BIT   = 0;
   localparam int OPR_ACCUM_LSB    = 0;
   localparam int OPR_CARRY_BIT    = 8;
   localparam int OPR_LATCH_BIT    = 9;
   localparam int STS_BUSY_BIT     = 0;
   localparam int STS_TAKEN_BIT    = 1;
   localparam int STS_ILLEGAL_BIT  = 2;
   localparam int STS_DONE_BIT     = 3;
   localparam int STS_FLAGS_LSB    = 4;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [15:0] PC_RST    = 16'h0000;
   localparam logic [7:0]  ACCUM_RST = 8'h00;
   localparam logic [7:0]  OPC_RST   = 8'h00;
   localparam logic [3:0]  FLAG_RST  = 4'hF;

   // ************************************************************
   // Opcodes and groups
   // ************************************************************
   localparam logic [3:0] GRP_SHORT     = 4'h3;
   localparam logic [7:0] OPC_LONG_JUMP = 8'hC0;
   localparam logic [7:0] OPC_LONG_ZERO = 8'hC2;
   localparam logic [7:0] OPC_SKIP_TWO  = 8'hC8;

   localparam int SEL_ALWAYS = 0;
   localparam int SEL_LATCH  = 1;
   localparam int SEL_ACCUM  = 2;
   localparam int SEL_CARRY  = 3;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_FETCH,
      ST_EXEC1,
      ST_EXEC2
   } brc_state_e;
endpackage
`default_nettype wire

// *** brc_cond_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface brc_cond_if;
   logic [2:0] sel;
   logic       invert;
   logic [7:0] accum;
   logic       carry;
   logic       latch;
   logic [3:0] flag_true;
   logic       taken;

   modport core (output sel, output invert, output accum, output carry,
                 output latch, output flag_true, input taken);
   modport mux  (input sel, input invert, input accum, input carry,
                 input latch, input flag_true, output taken);
endinterface
`default_nettype wire

// *** brc_cond_mux.sv ***
`timescale 1ns/100ps
`default_nettype none
module brc_cond_mux (
   brc_cond_if.mux cif
);
   import brc_pkg::*;

   logic raw;

   // ************************************************************
   // Source select, top bit of the low nibble flips the sense
   // ************************************************************
   always_comb begin
      case (cif.sel)
         3'(SEL_ALWAYS): raw = 1'b1;
         3'(SEL_LATCH):  raw = cif.latch;           // RULE_05
         3'(SEL_ACCUM):  raw = (cif.accum == 8'h00); // RULE_01
         3'(SEL_CARRY):  raw = cif.carry;           // RULE_03
         default:        raw = cif.flag_true[cif.sel[1:0]]; // RULE_07
      endcase
   end

   // Inverted sense covers 3A, 3B, 39 and 3C..3F
   assign cif.taken = raw ^ cif.invert; // RULE_18
   // Nonzero test                        RULE_02
   // Carry clear, all three names same   RULE_04
   // Latch clear                         RULE_06
   // Flag pin high                       RULE_08
endmodule
`default_nettype wire

// *** brc_pin_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module brc_pin_sync #(
   parameter int W = 4
) (
   input  wire logic         core_clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] pin_n,
   output logic      [W-1:0] level_n
);
   import brc_pkg::*;

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] stable;
   } brc_sync_s;

   brc_sync_s q, d;

   // ************************************************************
   // Three stages; a change counts once stages two and three agree
   // ************************************************************
   always_comb begin
      d        = q;
      d.s1     = pin_n;
      d.s2     = q.s1;
      d.s3     = q.s2;
      // Pins are expected steady while tested RULE_09
      d.stable = (q.s2 & q.s3) | (q.stable & (q.s2 ^ q.s3));
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         q <= {4{W'(FLAG_RST)}};
      end else begin
         q <= d;
      end
   end

   assign level_n = q.stable;
endmodule
`default_nettype wire

// *** brc_branch_unit.sv ***
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// RULE_01: 32 jumps when accumulator is zero
// RULE_02: 3A jumps when accumulator is nonzero
// RULE_03: 33 jumps when carry is set
// RULE_04: 3B jumps when carry is clear
// RULE_05: 31 jumps when output latch set
// RULE_06: 39 jumps when output latch clear
// RULE_07: 34..37 jump when flag pin low
// RULE_08: 3C..3F jump when flag pin high
// RULE_09: Outside circuits hold flag pins steady
// RULE_10: Failed short jump steps counter by one
// RULE_11: Long forms: fetch plus two execute cycles
// RULE_12: C0 loads counter, high byte first
// RULE_13: C8 steps counter by two
// RULE_14: C2 loads when accumulator zero, else skips
// RULE_15: Taken short jump replaces low byte only
// RULE_16: Page taken from the immediate byte
// RULE_17: Short forms: fetch plus one execute
// RULE_18: Low nibble selects source, bit three inverts
module brc_branch_unit (
   input  wire logic        core_clk,
   input  wire logic        rst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Program memory
   output logic      [15:0] mem_addr,
   output logic             mem_rd,
   input  wire logic [7:0]  mem_rdata,
   input  wire logic        mem_rvalid,
   // External flag pins, low is true
   input  wire logic [3:0]  ext_flag_in_n
);
   import brc_pkg::*;

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      brc_state_e  st;
      logic [15:0] pc;
      logic [7:0]  accum;
      logic        carry_flag;
      logic        latch;
      logic [7:0]  opcode;
      logic [7:0]  hi;
      logic        long_go;
      logic        taken;
      logic        illegal;
      logic        done;
      logic [31:0] prdata;
   } brc_core_s;

   brc_core_s q, d;

   logic [3:0] flag_lvl_n;
   logic       acc_wr;
   logic       is_short;
   logic       is_long;
   logic       hit;
   logic [31:0] rd_mux;
   logic [15:0] pc_inc;
   logic       wr_ctrl;
   logic       wr_opr;
   logic       wr_pc;
   logic       wr_sts;

   brc_cond_if cif ();

   // ************************************************************
   // Pin synchronisers and condition select
   // ************************************************************
   brc_pin_sync #(
      .W (4)
   ) u_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .pin_n    (ext_flag_in_n),
      .level_n  (flag_lvl_n)
   );

   brc_cond_mux u_cond (
      .cif (cif)
   );

   assign cif.sel       = q.opcode[2:0];      // RULE_18
   assign cif.invert    = q.opcode[3];        // RULE_18
   assign cif.accum     = q.accum;
   assign cif.carry     = q.carry_flag;
   assign cif.latch     = q.latch;
   assign cif.flag_true = ~flag_lvl_n;        // RULE_07

   // ************************************************************
   // APB decode
   // ************************************************************
   // Zero wait states: the answer comes in the access phase
   assign pready = 1'b1;
   assign acc_wr = psel & penable & pwrite;

   // ************************************************************
   // Write strobes, one per writable register
   // ************************************************************
   // Decoded once so the next-state logic reads plainly
   always_comb begin
      wr_ctrl = 1'b0;
      wr_opr  = 1'b0;
      wr_pc   = 1'b0;
      wr_sts  = 1'b0;
      if (acc_wr) begin
         case (paddr)
            OFS_CTRL:    wr_ctrl = 1'b1;
            OFS_OPERAND: wr_opr  = 1'b1;
            OFS_PC:      wr_pc   = 1'b1;
            OFS_STATUS:  wr_sts  = 1'b1;
            default: begin
               // Read-only offsets and holes drop the write
               wr_ctrl = 1'b0;
            end
         endcase
      end
   end

   always_comb begin
      hit = 1'b1;
      rd_mux = 32'h0000_0000;
      case (paddr)
         OFS_CTRL: begin
            rd_mux[CTRL_START_BIT] = 1'b0;
         end
         OFS_OPERAND: begin
            rd_mux[OPR_ACCUM_LSB +: 8] = q.accum;
            rd_mux[OPR_CARRY_BIT]      = q.carry_flag;
            rd_mux[OPR_LATCH_BIT]      = q.latch;
         end
         OFS_PC: begin
            rd_mux[15:0] = q.pc;
         end
         OFS_STATUS: begin
            rd_mux[STS_BUSY_BIT]        = (q.st != ST_IDLE);
            rd_mux[STS_TAKEN_BIT]       = q.taken;
            rd_mux[STS_ILLEGAL_BIT]     = q.illegal;
            rd_mux[STS_DONE_BIT]        = q.done;
            rd_mux[STS_FLAGS_LSB +: 4]  = flag_lvl_n;
         end
         OFS_OPCODE: begin
            rd_mux[7:0] = q.opcode;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   // Unmapped addresses answer with an error and zero data
   assign pslverr = psel & penable & ~hit;
   assign prdata  = q.prdata;

   // ************************************************************
   // Memory request
   // ************************************************************
   // Held until the memory answers; address comes from the counter
   assign mem_rd   = (q.st != ST_IDLE);
   assign mem_addr = q.pc;
   assign pc_inc   = q.pc + 16'h0001;

   assign is_short = (mem_rdata[7:4] == GRP_SHORT);
   assign is_long  = (mem_rdata == OPC_LONG_JUMP) |
                     (mem_rdata == OPC_LONG_ZERO) |
                     (mem_rdata == OPC_SKIP_TWO);

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      d = q;

      // Read data is captured in the setup phase, so it is a flop
      if (psel & ~penable) begin
         d.prdata = rd_mux;
      end

      // Operand writes are allowed any time; the condition is
      // sampled only in the execute cycle
      if (wr_opr) begin
         d.accum      = pwdata[OPR_ACCUM_LSB +: 8];
         d.carry_flag = pwdata[OPR_CARRY_BIT];
         d.latch      = pwdata[OPR_LATCH_BIT];
      end

      // Counter writes while busy would corrupt a walk; ignored
      if (wr_pc && q.st == ST_IDLE) begin
         d.pc = pwdata[15:0];
      end

      // Done is write-one-to-clear; completion below wins
      if (wr_sts && pwdata[STS_DONE_BIT]) begin
         d.done = 1'b0;
      end

      case (q.st)
         ST_IDLE: begin
            // Start seen only here, so a start while busy is dropped
            if (wr_ctrl && pwdata[CTRL_START_BIT]) begin
               d.st      = ST_FETCH;
               d.taken   = 1'b0;
               d.illegal = 1'b0;
            end
         end

         ST_FETCH: begin
            if (mem_rvalid) begin
               d.opcode = mem_rdata;
               d.pc     = pc_inc;
               if (is_short | is_long) begin
                  d.st = ST_EXEC1;
               end else begin
                  // Only branch group handled here
                  d.illegal = 1'b1;
                  d.done    = 1'b1;
                  d.st      = ST_IDLE;
               end
            end
         end

         ST_EXEC1: begin
            if (mem_rvalid) begin
               if (q.opcode[7:4] == GRP_SHORT) begin
                  // Single execute cycle RULE_17
                  d.taken = cif.taken;
                  if (cif.taken) begin
                     // High byte kept: page of the immediate byte RULE_16
                     d.pc[7:0] = mem_rdata; // RULE_15
                  end else begin
                     d.pc = pc_inc; // RULE_10
                  end
                  d.done = 1'b1;
                  d.st   = ST_IDLE;
               end else begin
                  // First of two execute cycles RULE_11
                  d.hi = mem_rdata; // RULE_12
                  d.pc = pc_inc;
                  case (q.opcode)
                     OPC_LONG_JUMP: d.long_go = 1'b1; // RULE_12
                     OPC_LONG_ZERO: d.long_go = (q.accum == 8'h00); // RULE_14
                     default:       d.long_go = 1'b0; // RULE_13
                  endcase
                  d.st = ST_EXEC2;
               end
            end
         end

         ST_EXEC2: begin
            if (mem_rvalid) begin
               d.taken = q.long_go;
               if (q.long_go) begin
                  d.pc = {q.hi, mem_rdata}; // RULE_12
               end else begin
                  d.pc = pc_inc; // RULE_13
               end
               d.done = 1'b1;
               d.st   = ST_IDLE; // RULE_11
            end
         end

         default: begin
            d.st = ST_IDLE;
         end
      endcase
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         q.st         <= ST_IDLE;
         q.pc         <= PC_RST;
         q.accum      <= ACCUM_RST;
         q.carry_flag <= 1'b0;
         q.latch      <= 1'b0;
         q.opcode     <= OPC_RST;
         q.hi         <= 8'h00;
         q.long_go    <= 1'b0;
         q.taken      <= 1'b0;
         q.illegal    <= 1'b0;
         q.done       <= 1'b0;
         q.prdata     <= 32'h0000_0000;
      end else begin
         q <= d;
      end
   end
endmodule
`default_nettype wire

// *** brc_mem_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Program memory and flag pin drivers
// ****************************************
module brc_mem_model (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic [15:0] mem_addr,
   input  wire logic        mem_rd,
   input  wire logic [1:0]  slow,
   input  wire logic [3:0]  flag_true,
   output logic      [7:0]  mem_rdata,
   output logic             mem_rvalid,
   output logic      [3:0]  ext_flag_in_n
);
   logic [7:0] mem [0:65535];
   logic [1:0] wait_q;
   logic [7:0] last_q;
   assign mem_rvalid = mem_rd && (wait_q >= slow);
   // Inverted last byte so a stale sample never matches
   assign mem_rdata = mem_rvalid ? mem[mem_addr] : ~last_q;
   assign ext_flag_in_n = ~flag_true;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wait_q <= 2'h0;
         last_q <= 8'h00;
      end else if (mem_rvalid) begin
         wait_q <= 2'h0;
         last_q <= mem_rdata;
      end else if (mem_rd && wait_q != 2'h3) begin
         wait_q <= wait_q + 2'h1;
      end
   end
endmodule
`default_nettype wire

// *** brc_branch_unit_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
module brc_branch_unit_checker (
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic [15:0] mem_addr,
   input wire logic        mem_rd,
   input wire logic [7:0]  mem_rdata,
   input wire logic        mem_rvalid
);
   import brc_pkg::*;
   logic        acc;
   logic [1:0]  cnt_q;
   logic [7:0]  opc_q;
   logic [7:0]  hi_q;
   logic [7:0]  dat_q;
   logic [15:0] ia_q;
   assign acc = mem_rd && mem_rvalid;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 2'h0;
         opc_q <= 8'h00;
         hi_q <= 8'h00;
         dat_q <= 8'h00;
         ia_q <= 16'h0000;
      end else if (acc) begin
         cnt_q <= cnt_q + 2'h1;
         dat_q <= mem_rdata;
         ia_q <= mem_addr;
         if (cnt_q == 2'h0) opc_q <= mem_rdata;
         if (cnt_q == 2'h1) hi_q <= mem_rdata;
      end else if (!mem_rd) begin
         cnt_q <= 2'h0;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   AST_MEM_HOLD: assert property (mem_rd && !mem_rvalid |=> mem_rd && $stable(mem_addr))
      else $error("memory request dropped");
   AST_SEQ_ADDR: assert property (acc |=> !mem_rd || mem_addr == ia_q + 16'h1)
      else $error("read address not sequential");
   AST_BURST_MAX: assert property (acc |-> cnt_q != 2'h3)
      else $error("more than three reads");
   AST_SHORT_LEN: assert property (acc && cnt_q == 2'h1 && opc_q[7:4] == GRP_SHORT |=> !mem_rd)
      else $error("short form too long");
   AST_SHORT_PC: assert property (acc && cnt_q == 2'h1 && opc_q[7:4] == GRP_SHORT
      |=> mem_addr == {ia_q[15:8], dat_q} || mem_addr == ia_q + 16'h1) else $error("short target wrong");
   AST_LONG_LEN: assert property (acc && cnt_q == 2'h1 && opc_q[7:4] == 4'hC |=> mem_rd)
      else $error("long form too short");
   AST_LONG_JUMP: assert property (acc && cnt_q == 2'h2 && opc_q == OPC_LONG_JUMP
      |=> !mem_rd && mem_addr == {hi_q, dat_q}) else $error("long target wrong");
   AST_SKIP_TWO: assert property (acc && cnt_q == 2'h2 && opc_q == OPC_SKIP_TWO
      |=> !mem_rd && mem_addr == ia_q + 16'h1) else $error("skip address wrong");
   AST_LONG_ZERO: assert property (acc && cnt_q == 2'h2 && opc_q == OPC_LONG_ZERO
      |=> mem_addr == {hi_q, dat_q} || mem_addr == ia_q + 16'h1) else $error("zero jump wrong");
   cover property (acc && cnt_q == 2'h1 && opc_q[7:4] == GRP_SHORT);
   cover property (acc && cnt_q == 2'h2 && opc_q == OPC_LONG_JUMP);
   cover property (acc && cnt_q == 2'h2 && opc_q == OPC_LONG_ZERO);
endmodule
bind brc_branch_unit brc_branch_unit_checker i_chk (.core_clk, .rst, .mem_addr, .mem_rd, .mem_rdata, .mem_rvalid);
`default_nettype wire

// *** branch_condition_pc_update_test.sv ***
`timescale 1ns/100ps
`default_nettype none
module branch_condition_pc_update_test;
   import brc_pkg::*;
   logic        core_clk, rst, psel, penable, pwrite, pready, pslverr, mem_rd, mem_rvalid;
   logic [7:0]  paddr, mem_rdata;
   logic [31:0] pwdata, prdata;
   logic [15:0] mem_addr;
   logic [3:0]  ext_flag_in_n, flag_true;
   logic [1:0]  slow;
   int          fail_count, compares;
   brc_branch_unit i_dut (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .mem_addr, .mem_rd, .mem_rdata, .mem_rvalid, .ext_flag_in_n);
   brc_mem_model i_mem (.core_clk, .rst, .mem_addr, .mem_rd, .slow, .flag_true, .mem_rdata,
      .mem_rvalid, .ext_flag_in_n);
   always #2.5 core_clk = ~core_clk;
   // ****************************************
   // Bus and check tasks
   // ****************************************
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      compares++;
      if (got !== ex) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic run(input logic [15:0] pc, input logic [7:0] op, b1, b2, input logic [15:0] ex, input logic tk,
                      input string nm);
      logic [31:0] r;
      logic        e;
      int          n;
      i_mem.mem[pc] = op;
      i_mem.mem[pc + 16'h1] = b1;
      i_mem.mem[pc + 16'h2] = b2;
      wr(OFS_PC, {16'h0000, pc});
      wr(OFS_CTRL, 32'h0000_0001);
      n = 0;
      r = 32'h0;
      while (r[STS_DONE_BIT] !== 1'b1 && n < 40) begin
         apb(1'b0, OFS_STATUS, 32'h0, r, e);
         n++;
      end
      chk({nm, " done"}, 32'h1, {31'h0, r[STS_DONE_BIT]});
      chk({nm, " taken"}, {31'h0, tk}, {31'h0, r[STS_TAKEN_BIT]});
      wr(OFS_STATUS, 32'h0000_0008);
      apb(1'b0, OFS_PC, 32'h0, r, e);
      chk(nm, {16'h0000, ex}, r);
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      logic [31:0] r;
      logic        e;
      apb(1'b0, OFS_PC, 32'h0, r, e);
      chk("pc reset", {16'h0000, PC_RST}, r);
      apb(1'b0, OFS_STATUS, 32'h0, r, e);
      chk("flag levels", {28'h0, FLAG_RST}, {28'h0, r[STS_FLAGS_LSB +: 4]});
      apb(1'b0, 8'h40, 32'h0, r, e);
      chk("unmapped error", 32'h1, {31'h0, e});
   endtask
   task automatic t_short(input logic [7:0] ac, input logic cy, q, input logic [3:0] ft, input logic [1:0] sp);
      logic        c;
      logic [7:0]  op;
      logic [7:0]  im;
      logic [31:0] r;
      logic        e;
      flag_true <= ft;
      slow <= sp;
      wr(OFS_OPERAND, {22'h0, q, cy, ac});
      apb(1'b0, OFS_OPERAND, 32'h0, r, e);
      chk("operand", {22'h0, q, cy, ac}, r);
      apb(1'b0, OFS_STATUS, 32'h0, r, e);
      chk("flag levels", {28'h0, ~ft}, {28'h0, r[STS_FLAGS_LSB +: 4]});
      for (int n = 0; n < 16; n++) begin
         op = 8'h30 + 8'(n);
         im = 8'h40 + 8'(n);
         case (n[2:0])
            3'd0: c = 1'b1;
            3'd1: c = q;
            3'd2: c = (ac == 8'h00);
            3'd3: c = cy;
            default: c = ft[n[1:0]];
         endcase
         c = c ^ n[3];
         // Opcode on the last two bytes of a page
         run(16'h12FE, op, im, 8'h00, c ? {8'h12, im} : 16'h1300, c, "short pc");
      end
   endtask
   task automatic t_long();
      logic [31:0] r;
      logic        e;
      slow <= 2'd1;
      wr(OFS_OPERAND, 32'h0);
      run(16'h4080, OPC_LONG_JUMP, 8'h25, 8'h3A, 16'h253A, 1'b1, "long jump");
      run(16'h40FF, OPC_SKIP_TWO, 8'h5A, 8'h2B, 16'h4102, 1'b0, "skip two");
      run(16'h5000, OPC_LONG_ZERO, 8'h1A, 8'h33, 16'h1A33, 1'b1, "zero jump");
      wr(OFS_OPERAND, 32'h0000_0007);
      run(16'h5000, OPC_LONG_ZERO, 8'h1A, 8'h33, 16'h5003, 1'b0, "zero skip");
      // Opcode outside the branch group: flagged, counter steps past it
      run(16'h6000, 8'h7B, 8'h00, 8'h00, 16'h6001, 1'b0, "illegal pc");
      apb(1'b0, OFS_STATUS, 32'h0, r, e);
      chk("illegal bit", 32'h1, {31'h0, r[STS_ILLEGAL_BIT]});
      apb(1'b0, OFS_OPCODE, 32'h0, r, e);
      chk("opcode reg", 32'h0000_007B, r);
   endtask
   task automatic results();
      $display("Compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      rst = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      slow = 2'd0;
      flag_true = 4'h0;
      fail_count = 0;
      compares = 0;
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      t_reset();
      t_short(8'h00, 1'b1, 1'b0, 4'b0101, 2'd0);
      t_short(8'h5A, 1'b0, 1'b1, 4'b1010, 2'd2);
      t_long();
      results();
   end
   // Generous bound, runs take a few thousand ns
   initial begin
      #200000;
      fail_count++;
      results();
   end
endmodule
`default_nettype wire
